// file: logic/sss_supervisor.sv
// safe stop supervisor: controlled stop, torque-off, brake control, guards
`timescale 1ns/1ps
`include "sss_cfg.svh"

// Contract
// - permanent guards activate after run-up; run state entered; no runtime change
// - permanent guards supervised continuously, no input, no delay
// - permanence only for direction, speed, range, position guards and monitors
// - reset refused while position guard sees axis out of range
// - permanent monitor needs hysteresis; set/reset mode unavailable
// - torque-off on request, stop standstill/timeout, ramp monitor error
// - torque-off active puts device into torque-off state
// - brake output low while torque-off active
// - torque-off released: brake follows config, optional trigger link, high releases
// - in torque-off feedbacks low except torque-off ack and brake test active
// - controlled stop brakes to standstill then invokes torque-off
// - exactly one controlled stop instance, always present
// - reset of module accepted via controlled stop activation inputs
// - stop triggered by input, guard limit violation or internal error
// - brake ramp drive-activated by default or controller-activated
// - drive mode: send ramp to drive, start braking, monitor it
// - controller mode: ramp and start signal over fieldbus, braking monitored
// - normal ramp normally, emergency ramp when braking caused by error
// - both ramp gradients accept 0..2147483647, default 5000000
// - with ramp monitoring the ramp must be at least 2
// - braking duration follows speed at start, no fixed time
// - stop and torque-off requests are active low
// - stop and torque-off acknowledges are active high
// - torque-off forced after delay: normal 0..120000 ms def 100, error def 50
// - serious fault: torque-off at once, restart only by power cycle
module sss_supervisor #(
    parameter int unsigned MS_CYCLES = `SSS_MS_CYCLES  // clocks per millisecond
) (
    input  wire logic                   clock_i,                // 100 MHz
    input  wire logic                   rst_i,                  // async, high
    input  wire logic                   wb_cyc_i,               // wishbone cycle
    input  wire logic                   wb_stb_i,               // wishbone strobe
    input  wire logic                   wb_we_i,                // write enable
    input  wire logic [`SSS_ADDR_W-1:0] wb_adr_i,               // byte address
    input  wire logic [3:0]             wb_sel_i,               // byte enables
    input  wire logic [31:0]            wb_dat_i,               // write data
    output logic      [31:0]            wb_dat_o,               // read data
    output logic                        wb_ack_o,               // acknowledge
    output logic                        wb_err_o,               // unmapped access
    input  wire logic                   stop_request_n_i,       // pin, low activates
    input  wire logic                   torque_off_request_n_i, // pin, low activates
    input  wire sss_pkg::sss_drive_t    drive_i,                // drive status flags
    input  wire logic                   brake_test_i,           // brake test running
    input  wire logic [7:0]             guard_ok_i,             // guards within limits
    output logic                        stop_active_ack_o,      // stop active
    output logic                        torque_off_active_ack_o,// torque-off active
    output logic                        brake_control_o,        // high releases brake
    output logic                        brake_test_active_o,    // brake test feedback
    output logic [7:0]                  guard_ok_o,             // guard feedbacks
    output logic                        torque_off_o,           // to power stage
    output logic                        ignore_setpoints_o,     // drive ignores setpoints
    output sss_pkg::sss_ramp_t          ramp_o                  // ramp to drive/fieldbus
);
    import sss_pkg::*;

    // pin synchronisers, first stage read only by the second
    logic [1:0] stop_sync;
    logic [1:0] to_sync;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            stop_sync <= 2'h0;
            to_sync   <= 2'h0;
        end else begin
            stop_sync <= {stop_sync[0], stop_request_n_i};
            to_sync   <= {to_sync[0], torque_off_request_n_i};
        end
    end
    logic stop_req;
    logic to_req;
    assign stop_req = ~stop_sync[1];

    // register file
    logic [31:0] ctrl;
    logic [31:0] ramp;
    logic [31:0] estop_brake_gradient;
    logic [31:0] delay_ms;
    logic [31:0] edelay_ms;
    logic [15:0] guard_cfg;
    sss_state_t  state;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ramp accepted only inside the legal range
    function automatic logic ramp_ok(input logic [31:0] v, input logic mon);
        return (v <= `SSS_RAMP_MAX) && (!mon || v >= `SSS_RAMP_MIN_MON);
    endfunction

    assign to_req = ctrl[`SSS_CTRL_TO_IN_EN] & ~to_sync[1];

    logic req;
    logic wr;
    logic mapped;
    logic cfg_open;
    logic [31:0] wv;
    assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign wr       = req & wb_we_i & mapped;
    // guard configuration frozen once running: no runtime guard changes
    assign cfg_open = (state == SSS_RUNUP);
    assign wv       = wb_dat_i;

    always_comb begin
        unique case (wb_adr_i)
            `SSS_REG_CTRL, `SSS_REG_RAMP, `SSS_REG_ESTOP_RAMP, `SSS_REG_DELAY,
            `SSS_REG_EDELAY, `SSS_REG_STATUS, `SSS_REG_GUARD: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    logic [31:0] m;
    assign m = merge(32'h0, wv, wb_sel_i);

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl                 <= 32'h0000_0000;    // drive-activated default
            ramp                 <= `SSS_RAMP_DEF;
            estop_brake_gradient <= `SSS_RAMP_DEF;
            delay_ms             <= `SSS_DELAY_DEF_MS;
            edelay_ms            <= `SSS_EDELAY_DEF_MS;
            guard_cfg            <= 16'h0000;         // permanence off by default
        end else if (wr) begin
            unique case (wb_adr_i)
                `SSS_REG_CTRL: begin
                    ctrl <= merge(ctrl, wv, wb_sel_i) & 32'h0000_003F;
                end
                `SSS_REG_RAMP: begin
                    if (ramp_ok(merge(ramp, wv, wb_sel_i), ctrl[`SSS_CTRL_RAMP_MON])) begin
                        ramp <= merge(ramp, wv, wb_sel_i);
                    end
                end
                `SSS_REG_ESTOP_RAMP: begin
                    if (ramp_ok(merge(estop_brake_gradient, wv, wb_sel_i),
                                ctrl[`SSS_CTRL_RAMP_MON])) begin
                        estop_brake_gradient <= merge(estop_brake_gradient, wv, wb_sel_i);
                    end
                end
                `SSS_REG_DELAY: begin
                    if (merge(delay_ms, wv, wb_sel_i) <= `SSS_DELAY_MAX_MS) begin
                        delay_ms <= merge(delay_ms, wv, wb_sel_i);
                    end
                end
                `SSS_REG_EDELAY: begin
                    if (merge(edelay_ms, wv, wb_sel_i) <= `SSS_DELAY_MAX_MS) begin
                        edelay_ms <= merge(edelay_ms, wv, wb_sel_i);
                    end
                end
                `SSS_REG_GUARD: begin
                    if (cfg_open) begin
                        // monitor permanence forces hysteresis on
                        guard_cfg <= {m[15:12] | m[7:4], m[11:0]};
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            wb_ack_o <= req & mapped;
            wb_err_o <= req & ~mapped;
        end
    end

    // state machine
    logic        stop_act;
    logic        stop_err;
    logic [31:0] ms_cnt;
    logic [31:0] ms_left;
    logic [31:0] pre_cnt;
    logic        ms_tick;
    logic        fault_stop;
    logic        ramp_fail;
    logic        reset_ok;
    logic        start_done;

    assign ms_tick    = (pre_cnt == MS_CYCLES - 1);
    assign fault_stop = drive_i.limit_fault | drive_i.internal_fault;
    // ramp monitor error: drive mode or configured torque-off reaction
    assign ramp_fail  = ctrl[`SSS_CTRL_RAMP_MON] & drive_i.ramp_fault &
                        (~ctrl[`SSS_CTRL_CTRL_ACT] | ctrl[`SSS_CTRL_RAMP_ERR_TO]);
    // reset via stop inputs, refused while position guard out of range
    assign reset_ok   = ~stop_req & ~to_req & ~fault_stop &
                        ~((guard_cfg[`SSS_GUARD_SLP] | guard_cfg[`SSS_GUARD_SLP_M]) &
                          drive_i.out_of_range);

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pre_cnt <= 32'h0;
        end else begin
            pre_cnt <= ms_tick ? 32'h0 : pre_cnt + 32'h1;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state      <= SSS_RUNUP;
            stop_err   <= 1'b0;
            ms_left    <= 32'h0;
            start_done <= 1'b0;
        end else begin
            if (drive_i.serious_fault) begin
                state <= SSS_FATAL;
            end else begin
                unique case (state)
                    SSS_RUNUP: begin
                        state <= SSS_RUN;
                    end
                    SSS_RUN: begin
                        if (to_req) begin
                            state <= SSS_TORQUE;
                        end else if (stop_req | fault_stop) begin
                            state    <= SSS_BRAKING;
                            stop_err <= fault_stop;
                            ms_left  <= fault_stop ? edelay_ms : delay_ms;
                        end
                    end
                    SSS_BRAKING: begin
                        if (fault_stop) begin
                            stop_err <= 1'b1;
                        end
                        if (ms_tick && ms_left != 32'h0) begin
                            ms_left <= ms_left - 32'h1;
                        end
                        // end set by standstill, torque-off request, ramp error or ms delay running out
                        if (to_req | drive_i.standstill | ramp_fail | ms_left == 32'h0) begin
                            state <= SSS_TORQUE;
                        end
                    end
                    SSS_TORQUE: begin
                        stop_err <= 1'b0;
                        if (reset_ok) begin
                            state <= SSS_RUN;
                        end
                    end
                    SSS_FATAL: begin
                        state <= SSS_FATAL;
                    end
                    default: state <= SSS_FATAL;
                endcase
            end
            start_done <= (state == SSS_BRAKING);
        end
    end

    logic to_active;
    logic br_active;
    assign to_active = (state == SSS_TORQUE) | (state == SSS_FATAL);
    assign br_active = (state == SSS_BRAKING);

    // outputs from flip-flops
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            torque_off_o            <= 1'b1;
            torque_off_active_ack_o <= 1'b0;
            stop_active_ack_o       <= 1'b0;
            brake_control_o         <= 1'b0;
            brake_test_active_o     <= 1'b0;
            guard_ok_o              <= 8'h00;
            ignore_setpoints_o      <= 1'b0;
            ramp_o                  <= '0;
        end else begin
            torque_off_o            <= to_active | (state == SSS_RUNUP);
            torque_off_active_ack_o <= to_active;
            stop_active_ack_o       <= br_active;
            brake_control_o         <= ~to_active & ctrl[`SSS_CTRL_BRK_EN] &
                                       (~ctrl[`SSS_CTRL_BRK_LINK] | drive_i.brake_trigger);
            brake_test_active_o     <= brake_test_i;
            // guard feedback is guard_ok_i registered one cycle, forced low in torque-off
            guard_ok_o              <= to_active ? 8'h00 : guard_ok_i;
            ignore_setpoints_o      <= br_active & ~ctrl[`SSS_CTRL_CTRL_ACT];
            ramp_o.start            <= br_active & ~start_done;
            ramp_o.estop            <= stop_err;
            ramp_o.gradient         <= (br_active & stop_err) ? estop_brake_gradient : ramp;
        end
    end

    // read mux
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0;
        end else if (req) begin
            unique case (wb_adr_i)
                `SSS_REG_CTRL:       wb_dat_o <= ctrl;
                `SSS_REG_RAMP:       wb_dat_o <= ramp;
                `SSS_REG_ESTOP_RAMP: wb_dat_o <= estop_brake_gradient;
                `SSS_REG_DELAY:      wb_dat_o <= delay_ms;
                `SSS_REG_EDELAY:     wb_dat_o <= edelay_ms;
                `SSS_REG_STATUS:     wb_dat_o <= {26'h0, stop_err, ramp_o.start, to_active,
                                                  state};
                `SSS_REG_GUARD:      wb_dat_o <= {16'h0, guard_cfg};
                default:             wb_dat_o <= 32'h0;
            endcase
        end
    end
endmodule // sss_supervisor

// file: shared/sss_cfg.svh
// constants for the safe stop supervisor: offsets, fields, resets, timing
`ifndef SSS_CFG_SVH
`define SSS_CFG_SVH
`define SSS_ADDR_W          8
`define SSS_REG_CTRL        8'h00
`define SSS_REG_RAMP        8'h04
`define SSS_REG_ESTOP_RAMP  8'h08
`define SSS_REG_DELAY       8'h0C
`define SSS_REG_EDELAY      8'h10
`define SSS_REG_STATUS      8'h14
`define SSS_REG_GUARD       8'h18
// ctrl fields
`define SSS_CTRL_CTRL_ACT   0
`define SSS_CTRL_RAMP_MON   1
`define SSS_CTRL_TO_IN_EN   2
`define SSS_CTRL_BRK_LINK   3
`define SSS_CTRL_BRK_EN     4
`define SSS_CTRL_RAMP_ERR_TO 5
// guard register: bits 7:0 permanent enables, 15:8 hysteresis selects
`define SSS_GUARD_N         8
`define SSS_GUARD_SLP       3
`define SSS_GUARD_SLP_M     7
`define SSS_RAMP_MAX        32'h7FFFFFFF
`define SSS_RAMP_DEF        32'h004C4B40
`define SSS_RAMP_MIN_MON    32'h00000002
`define SSS_DELAY_MAX_MS    32'd120000
`define SSS_DELAY_DEF_MS    32'd100
`define SSS_EDELAY_DEF_MS   32'd50
`define SSS_CLK_HZ          100000000
`define SSS_MS_CYCLES       (`SSS_CLK_HZ / 1000)
`endif

// file: shared/sss_pkg.sv
// types for the safe stop supervisor
package sss_pkg;
    typedef enum logic [2:0] {
        SSS_RUNUP   = 3'b000,
        SSS_RUN     = 3'b001,
        SSS_BRAKING = 3'b011,
        SSS_TORQUE  = 3'b010,
        SSS_FATAL   = 3'b110
    } sss_state_t;

    typedef struct packed {
        logic        start;      // braking start to controller
        logic        estop;      // emergency ramp selected
        logic [31:0] gradient;   // active ramp gradient
    } sss_ramp_t;

    typedef struct packed {
        logic standstill;
        logic ramp_fault;
        logic limit_fault;
        logic internal_fault;
        logic serious_fault;
        logic out_of_range;
        logic brake_trigger;
    } sss_drive_t;
endpackage

// file: bench/sss_drive_model.sv
// behavioural drive controller facing the safe stop supervisor
`timescale 1ns/1ps
module sss_drive_model #(
    parameter int SPEED = 12  // speed steps at braking start
) (
    input  wire logic                clock_i,      // clock
    input  wire logic                rst_i,        // async reset
    input  wire sss_pkg::sss_ramp_t  ramp_i,       // ramp from supervisor
    input  wire logic                torque_ack_i, // torque-off feedback
    input  wire logic                slow_i,       // stall the deceleration
    input  wire sss_pkg::sss_drive_t faults_i,     // fault flags from bench
    output sss_pkg::sss_drive_t      drive_o       // status to supervisor
);
    import sss_pkg::*;
    logic       braking;
    logic [7:0] speed;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i)
            braking <= 1'b0;
        else if (ramp_i.start)
            braking <= 1'b1;
        else if (torque_ack_i)
            braking <= 1'b0;
    end

    // setpoints are not modelled, so none can disturb a stop
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i)
            speed <= 8'(SPEED);
        else if (torque_ack_i)
            speed <= 8'(SPEED);
        else if (braking && !slow_i && speed != 8'h0)
            speed <= speed - 8'h1;
    end

    always_comb begin
        drive_o = faults_i;
        drive_o.standstill = braking && speed == 8'h0;
    end
endmodule // sss_drive_model

// file: bench/sss_supervisor_chk.sv
// concurrent checks on the safe stop supervisor ports
`timescale 1ns/1ps
module sss_supervisor_chk (
    input wire logic                clock_i,                 // clock
    input wire logic                rst_i,                   // async reset
    input wire logic                stop_request_n_i,        // stop pin
    input wire sss_pkg::sss_drive_t drive_i,                 // drive flags
    input wire logic                brake_test_i,            // brake test in
    input wire logic                stop_active_ack_o,       // stop ack
    input wire logic                torque_off_active_ack_o, // torque-off ack
    input wire logic                brake_control_o,         // brake out
    input wire logic                brake_test_active_o,     // brake test out
    input wire logic [7:0]          guard_ok_o,              // guard feedback
    input wire logic                torque_off_o,            // power stage
    input wire logic                ignore_setpoints_o,      // setpoint gate
    input wire sss_pkg::sss_ramp_t  ramp_o                   // ramp out
);
    import sss_pkg::*;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    sequence s_stop_fall;
        $fell(stop_request_n_i) && !stop_active_ack_o && !torque_off_active_ack_o;
    endsequence
    sequence s_fatal;
        drive_i.serious_fault ##2 1'b1;
    endsequence

    a_stop_start: assert property (s_stop_fall |-> ##[3:5] (stop_active_ack_o && ramp_o.start))
        else $error("stop request not answered");
    a_start_ack: assert property ($rose(stop_active_ack_o) |-> ramp_o.start)
        else $error("stop ack without ramp start");
    a_still_torque: assert property (stop_active_ack_o && drive_i.standstill
        |-> ##[1:3] torque_off_active_ack_o)
        else $error("standstill did not remove torque");
    a_brake_hold: assert property (torque_off_active_ack_o |-> !brake_control_o && torque_off_o)
        else $error("brake released during torque-off");
    a_fb_low: assert property (torque_off_active_ack_o |-> guard_ok_o == 8'h0 && !stop_active_ack_o)
        else $error("feedback high during torque-off");
    a_test_copy: assert property (brake_test_active_o == $past(brake_test_i))
        else $error("brake test feedback wrong");
    a_fatal_hold: assert property (s_fatal |-> torque_off_active_ack_o [*8])
        else $error("serious fault left torque on");
    a_ignore_stop: assert property (ignore_setpoints_o |-> stop_active_ack_o)
        else $error("setpoints ignored outside stop");
endmodule // sss_supervisor_chk

bind sss_supervisor sss_supervisor_chk u_chk (
    .clock_i(clock_i), .rst_i(rst_i), .stop_request_n_i(stop_request_n_i),
    .drive_i(drive_i), .brake_test_i(brake_test_i), .stop_active_ack_o(stop_active_ack_o),
    .torque_off_active_ack_o(torque_off_active_ack_o), .brake_control_o(brake_control_o),
    .brake_test_active_o(brake_test_active_o), .guard_ok_o(guard_ok_o),
    .torque_off_o(torque_off_o), .ignore_setpoints_o(ignore_setpoints_o), .ramp_o(ramp_o));

// file: bench/tb.sv
// register and stop sequence tests for the safe stop supervisor
`timescale 1ns/1ps
`include "sss_cfg.svh"
module tb;
    import sss_pkg::*;
    logic        clock_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, wb_err, stop_n, to_n, e;
    logic        btest, slow, stop_ack, to_ack, brake, btest_act, to_out, ign;
    logic [7:0]  wb_adr, gok_in, gok;
    logic [31:0] wb_wdat, wb_rdat, q;
    sss_drive_t  faults, drive;
    sss_ramp_t   ramp, last;
    int          n_fail = 0, total_checks = 0, n;

    sss_supervisor #(.MS_CYCLES(10)) dut (.clock_i(clock_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .wb_err_o(wb_err), .stop_request_n_i(stop_n), .torque_off_request_n_i(to_n),
        .drive_i(drive), .brake_test_i(btest), .guard_ok_i(gok_in),
        .stop_active_ack_o(stop_ack), .torque_off_active_ack_o(to_ack),
        .brake_control_o(brake), .brake_test_active_o(btest_act), .guard_ok_o(gok),
        .torque_off_o(to_out), .ignore_setpoints_o(ign), .ramp_o(ramp));
    sss_drive_model u_drive (.clock_i(clock_i), .rst_i(rst_i), .ramp_i(ramp),
        .torque_ack_i(to_ack), .slow_i(slow), .faults_i(faults), .drive_o(drive));

    // start is a one-cycle pulse, so keep what it carried
    always @(posedge clock_i) if (ramp.start === 1'b1) last <= ramp;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clock_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_wdat <= d;
        do begin
            @(posedge clock_i);
            k++;
        end while (!(wb_ack === 1'b1 || wb_err === 1'b1) && k < 20);
        q = wb_rdat;
        e = wb_err;
        chk(32'(k < 20), 32'h1);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    // bounded wait on one of the two acknowledges, n keeps the cycle count
    task automatic wait_ack(input bit torque, input int lim);
        n = 0;
        while ((torque ? to_ack : stop_ack) !== 1'b1 && n < lim) begin
            @(posedge clock_i);
            n++;
        end
        chk(32'(n < lim), 32'h1);
    endtask

    task automatic print_verdict;
        $display("checks=%0d fails=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    initial begin
        #100000;
        n_fail++;
        print_verdict();
    end

    initial begin
        rst_i = 1'b1;
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat, btest, slow} = '0;
        {stop_n, to_n} = 2'b11;
        faults = '0;
        faults.brake_trigger = 1'b1;
        gok_in = 8'hA5;
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        bus(1'b0, `SSS_REG_CTRL, 32'h0);
        chk({29'h0, q[2:0]}, 32'h0);
        rd(`SSS_REG_RAMP, `SSS_RAMP_DEF);
        rd(`SSS_REG_ESTOP_RAMP, `SSS_RAMP_DEF);
        rd(`SSS_REG_DELAY, `SSS_DELAY_DEF_MS);
        rd(`SSS_REG_EDELAY, `SSS_EDELAY_DEF_MS);
        bus(1'b0, 8'h1C, 32'h0);
        chk(32'(e), 32'h1);
        // guards are frozen once run-up is over
        bus(1'b1, `SSS_REG_GUARD, 32'hFF);
        rd(`SSS_REG_GUARD, 32'h0);
        bus(1'b1, `SSS_REG_RAMP, 32'h7FFFFFFF);
        bus(1'b1, `SSS_REG_RAMP, 32'h80000000);
        rd(`SSS_REG_RAMP, 32'h7FFFFFFF);
        bus(1'b1, `SSS_REG_CTRL, 32'h1A);
        bus(1'b1, `SSS_REG_RAMP, 32'h1);
        rd(`SSS_REG_RAMP, 32'h7FFFFFFF);
        bus(1'b1, `SSS_REG_RAMP, 32'h2);
        rd(`SSS_REG_RAMP, 32'h2);
        bus(1'b1, `SSS_REG_ESTOP_RAMP, 32'h1234);
        bus(1'b1, `SSS_REG_DELAY, 32'd120001);
        rd(`SSS_REG_DELAY, `SSS_DELAY_DEF_MS);
        bus(1'b1, `SSS_REG_DELAY, 32'h2);
        bus(1'b1, `SSS_REG_EDELAY, 32'h3);
        chk({brake, to_out, gok}, {2'b10, 8'hA5});
        faults.brake_trigger <= 1'b0;
        repeat (3) @(posedge clock_i);
        chk(32'(brake), 32'h0);
        faults.brake_trigger <= 1'b1;
        stop_n <= 1'b0;
        wait_ack(1'b0, 10);
        // one edge more so the captured ramp has landed
        @(posedge clock_i);
        chk(32'(ign), 32'h1);
        chk(32'(last.estop), 32'h0);
        chk(last.gradient, 32'h2);
        btest <= 1'b1;
        wait_ack(1'b1, 40);
        chk({brake, stop_ack, gok, btest_act}, 11'h1);
        stop_n <= 1'b1;
        btest <= 1'b0;
        repeat (8) @(posedge clock_i);
        chk({to_ack, brake}, 2'b01);
        slow <= 1'b1;
        stop_n <= 1'b0;
        wait_ack(1'b0, 10);
        wait_ack(1'b1, 40);
        // 2 ms at 10 clocks per ms; tick phase costs up to one ms early
        chk(32'(n >= 12 && n <= 21), 32'h1);
        stop_n <= 1'b1;
        slow <= 1'b0;
        bus(1'b1, `SSS_REG_CTRL, 32'h1B);
        for (int i = 0; i < 2; i++) begin
            faults.limit_fault <= (i == 0);
            faults.internal_fault <= (i == 1);
            wait_ack(1'b0, 10);
            @(posedge clock_i);
            chk(32'(ign), 32'h0);
            chk(32'(last.estop), 32'h1);
            chk(last.gradient, 32'h1234);
            wait_ack(1'b1, 40);
            faults.limit_fault <= 1'b0;
            faults.internal_fault <= 1'b0;
            repeat (8) @(posedge clock_i);
            chk(32'(to_ack), 32'h0);
        end
        bus(1'b1, `SSS_REG_CTRL, 32'h16);
        to_n <= 1'b0;
        wait_ack(1'b1, 8);
        to_n <= 1'b1;
        repeat (8) @(posedge clock_i);
        chk(32'(to_ack), 32'h0);
        slow <= 1'b1;
        stop_n <= 1'b0;
        wait_ack(1'b0, 10);
        faults.ramp_fault <= 1'b1;
        wait_ack(1'b1, 5);
        {stop_n, slow} <= 2'b10;
        faults.ramp_fault <= 1'b0;
        repeat (8) @(posedge clock_i);
        faults.serious_fault <= 1'b1;
        @(posedge clock_i);
        faults.serious_fault <= 1'b0;
        wait_ack(1'b1, 4);
        repeat (12) @(posedge clock_i);
        chk({to_ack, to_out}, 2'b11);
        print_verdict();
    end
endmodule // tb
